/* mbag_consts.svh */
// Constants of the mode based access guard: widths, address maps, fields.
// Assumes inclusion by bare name; definitions only.
`ifndef MBAG_CONSTS_SVH
`define MBAG_CONSTS_SVH

`define MBAG_VA_W        16
`define MBAG_PA_W        20
`define MBAG_NSEG        64
`define MBAG_DATA_W      16
`define MBAG_CFG_AW      10
`define MBAG_SFR_AW      8
`define MBAG_SFR_DW      8

// Physical memory map
`define MBAG_TROM_LO     20'h00000
`define MBAG_TROM_HI     20'h03FFF
`define MBAG_AROM_LO     20'h04000
`define MBAG_AROM_HI     20'h1FFFF
`define MBAG_ACM_LO      20'h1FFC0
`define MBAG_ACM_HI      20'h1FFFF
`define MBAG_MEE_LO      20'h20000
`define MBAG_MEE_HI      20'h2007F
`define MBAG_EEE_LO      20'h20080
`define MBAG_EEE_HI      20'h20FFF
`define MBAG_AEE_LO      20'h21000
`define MBAG_AEE_HI      20'h3FFFF
`define MBAG_SROW_LO     20'h21000
`define MBAG_SROW_HI     20'h2103F
`define MBAG_RAM_LO      20'h40000
`define MBAG_ERAM_HI     20'h403FF
`define MBAG_ARAM_LO     20'h40400
`define MBAG_ARAM_HI     20'h41FFF
`define MBAG_CRAM_LO     20'h42000
`define MBAG_CRAM_HI     20'h42FFF

// Register port map
`define MBAG_REG_PSW     10'h000
`define MBAG_REG_FWL     10'h001
`define MBAG_REG_FWH     10'h002
`define MBAG_REG_XBL     10'h003
`define MBAG_REG_XBH     10'h004
`define MBAG_REG_XSL     10'h005
`define MBAG_REG_XSH     10'h006
`define MBAG_REG_STAT    10'h007
`define MBAG_REG_FAULT   10'h008
`define MBAG_TBL_SEL     2'h1

// Field positions
`define MBAG_PSW_SYS     0
`define MBAG_PSW_EMU     1
`define MBAG_RT_R        0
`define MBAG_RT_W        1
`define MBAG_RT_X        2
`define MBAG_IST_BOOT    2'h1
`define MBAG_IST_TEST    2'h2
`define MBAG_PSW_RST     8'h00

// Register interface groups
`define MBAG_SFR_GEN_HI  8'h1F
`define MBAG_SFR_SEG_HI  8'h27
`define MBAG_SFR_SYS_HI  8'h2F
`define MBAG_SFR_FW_HI   8'h37
`define MBAG_SFR_EOS_HI  8'h3F
`define MBAG_SFR_TST_HI  8'h4F
`define MBAG_SFR_HW_LO   8'h80
`define MBAG_SFR_HW_HI   8'hBF
`define MBAG_SFR_PSW     8'h28

`endif

/* mbag_pkg.sv */
// Types shared by the access guard modules.
// Assumes mbag_consts.svh is on the include path.
`default_nettype none
`include "mbag_consts.svh"
package mbag_pkg;
  typedef enum logic [2:0] {
    MODE_BOOT = 3'h0, MODE_TEST = 3'h1, MODE_EMU = 3'h3,
    MODE_SYS = 3'h2, MODE_USER = 3'h6
  } mbag_mode_e;
  typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_EXEC = 2'h3} mbag_op_e;
  typedef enum logic [3:0] {
    REG_NONE = 4'h0, REG_TROM = 4'h1, REG_AROM = 4'h2, REG_MEE = 4'h3, REG_EEE = 4'h4,
    REG_AEE = 4'h5, REG_ERAM = 4'h6, REG_ARAM = 4'h7, REG_CRAM = 4'h8
  } mbag_region_e;
  typedef enum logic [2:0] {
    GRP_GEN = 3'h0, GRP_SEG = 3'h1, GRP_SYS = 3'h2, GRP_FW = 3'h3,
    GRP_EOS = 3'h4, GRP_TST = 3'h5, GRP_HW = 3'h6, GRP_NONE = 3'h7
  } mbag_grp_e;
  typedef struct packed {
    logic [2:0]            rights;
    logic [7:0]            hw;
    logic [`MBAG_VA_W-1:0] first;
    logic [`MBAG_VA_W-1:0] last;
    logic [`MBAG_VA_W-1:0] offset;
  } mbag_seg_s;
  typedef struct packed {
    mbag_op_e              op;
    logic                  cop;
    logic [`MBAG_VA_W-1:0] vaddr;
  } mbag_mem_req_s;
endpackage : mbag_pkg
`default_nettype wire

/* mbag_seg_match.sv */
// Segment table lookup: finds the lowest enabled entry covering an address.
// Assumes a table held by the caller; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "mbag_consts.svh"
module mbag_seg_match #(
  parameter int NSEG = `MBAG_NSEG
) (
  input  wire mbag_pkg::mbag_seg_s  table_in [NSEG],
  input  wire logic [`MBAG_VA_W-1:0] vaddr_in,
  output logic                       hit_out,
  output mbag_pkg::mbag_seg_s        entry_out
);
  import mbag_pkg::*;
  always_comb begin
    hit_out   = 1'b0;
    entry_out = '0;
    // Downward scan so the lowest index wins
    for (int i = NSEG - 1; i >= 0; i--) begin
      if (table_in[i].rights != 3'h0 && vaddr_in >= table_in[i].first &&
          vaddr_in <= table_in[i].last) begin
        hit_out   = 1'b1;
        entry_out = table_in[i];
      end
    end
  end
endmodule : mbag_seg_match
`default_nettype wire

/* mbag_guard.sv */
// Mode based access guard: address translation, memory and register checks.
// Assumes CPU requests synchronous to clk_in and a register file beside it.
`timescale 1ns/1ps
`default_nettype none
`include "mbag_consts.svh"
// Functional notes
// - Check read, write, execute and register ops
// - Five modes from status bits, state bits
// - Segment entry: rights, bounds, relocation offset
// - Segment entry carries hardware register rights
// - Rightless segment disabled; up to 64
// - Firewall and exchange window registers
// - Manufacturer EEPROM area reserved to test mode
// - Every virtual address translated to physical
// - Permission decided before memory is touched
// - Register access granted by current mode
// - Hardware rights from segment or firewall
// - Denied read gives zero, write ignored
// - Boot mode memory rights
// - Test mode memory rights
// - Emulation mode memory rights
// - System mode application memory rights
// - User mode rights from segment table
// - Emulation reads access condition matrix
// - Emulation reaches exchange window RAM
// - Boot and emulation read security rows
// - Coprocessor reads EEPROM, uses own RAM
// - Segmentation registers system mode only
// - General CPU registers open always
module mbag_guard #(
  parameter int NSEG = `MBAG_NSEG
) (
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic [1:0]                mode_state_in,
  input  wire logic [`MBAG_CFG_AW-1:0]   cfg_addr_in,
  input  wire logic [`MBAG_DATA_W-1:0]   cfg_wdata_in,
  input  wire logic                      cfg_wr_in,
  input  wire logic                      cfg_rd_in,
  output logic [`MBAG_DATA_W-1:0]        cfg_rdata_out,
  input  wire logic                      mem_req_in,
  input  wire mbag_pkg::mbag_mem_req_s   mem_cmd_in,
  output logic                           mem_grant_out,
  output logic                           mem_deny_out,
  output logic [`MBAG_PA_W-1:0]          mem_paddr_out,
  output mbag_pkg::mbag_op_e             mem_op_out,
  input  wire logic [`MBAG_VA_W-1:0]     cpu_pc_in,
  input  wire logic                      sfr_req_in,
  input  wire logic                      sfr_wr_in,
  input  wire logic [`MBAG_SFR_AW-1:0]   sfr_addr_in,
  input  wire logic [`MBAG_SFR_DW-1:0]   sfr_rdata_in,
  output logic                           sfr_grant_out,
  output logic                           sfr_deny_out,
  output logic                           sfr_we_out,
  output logic [`MBAG_SFR_DW-1:0]        sfr_rdata_out,
  output mbag_pkg::mbag_mode_e           mode_out
);
  import mbag_pkg::*;

  mbag_seg_s                table_q [NSEG];
  logic [7:0]               psw_high;
  logic [7:0]               fw_ctrl_low;
  logic [7:0]               fw_ctrl_high;
  logic [15:0]              xw_base;
  logic [15:0]              xw_size;
  logic [`MBAG_VA_W-1:0]    fault_vaddr;
  mbag_mode_e               mode;
  logic                     va_hit;
  logic                     pc_hit;
  mbag_seg_s                va_seg;
  mbag_seg_s                pc_seg;
  logic [`MBAG_PA_W-1:0]    next_paddr;
  mbag_region_e             region;
  logic                     is_rd;
  logic                     is_wr;
  logic                     is_ex;
  logic                     in_acm;
  logic                     in_srow;
  logic                     in_xwin;
  logic                     mem_ok;
  mbag_grp_e                grp;
  logic [2:0]               hw_comp;
  logic                     sfr_ok;
  logic                     cfg_tbl;
  logic                     cfg_wr_ok;
  logic                     cfg_rd_ok;

  function automatic logic in_rng(input logic [`MBAG_PA_W-1:0] a,
                                  input logic [`MBAG_PA_W-1:0] lo,
                                  input logic [`MBAG_PA_W-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_rng

  function automatic mbag_region_e region_of(input logic [`MBAG_PA_W-1:0] a);
    if (in_rng(a, `MBAG_TROM_LO, `MBAG_TROM_HI)) return REG_TROM;
    if (in_rng(a, `MBAG_AROM_LO, `MBAG_AROM_HI)) return REG_AROM;
    if (in_rng(a, `MBAG_MEE_LO, `MBAG_MEE_HI)) return REG_MEE;
    if (in_rng(a, `MBAG_EEE_LO, `MBAG_EEE_HI)) return REG_EEE;
    if (in_rng(a, `MBAG_AEE_LO, `MBAG_AEE_HI)) return REG_AEE;
    if (in_rng(a, `MBAG_RAM_LO, `MBAG_ERAM_HI)) return REG_ERAM;
    if (in_rng(a, `MBAG_ARAM_LO, `MBAG_ARAM_HI)) return REG_ARAM;
    if (in_rng(a, `MBAG_CRAM_LO, `MBAG_CRAM_HI)) return REG_CRAM;
    return REG_NONE;
  endfunction : region_of

  function automatic mbag_grp_e group_of(input logic [`MBAG_SFR_AW-1:0] a);
    if (a <= `MBAG_SFR_GEN_HI) return GRP_GEN;
    if (a <= `MBAG_SFR_SEG_HI) return GRP_SEG;
    if (a <= `MBAG_SFR_SYS_HI) return GRP_SYS;
    if (a <= `MBAG_SFR_FW_HI) return GRP_FW;
    if (a <= `MBAG_SFR_EOS_HI) return GRP_EOS;
    if (a <= `MBAG_SFR_TST_HI) return GRP_TST;
    if (a >= `MBAG_SFR_HW_LO && a <= `MBAG_SFR_HW_HI) return GRP_HW;
    return GRP_NONE;
  endfunction : group_of

  // Mode decode
  always_comb begin
    case (mode_state_in)
      `MBAG_IST_BOOT: mode = MODE_BOOT;
      `MBAG_IST_TEST: mode = MODE_TEST;
      default: begin
        if (psw_high[`MBAG_PSW_EMU]) mode = MODE_EMU;
        else if (psw_high[`MBAG_PSW_SYS]) mode = MODE_SYS;
        else mode = MODE_USER;
      end
    endcase
  end

  mbag_seg_match #(.NSEG(NSEG)) u_va_match (
    .table_in  (table_q),
    .vaddr_in  (mem_cmd_in.vaddr),
    .hit_out   (va_hit),
    .entry_out (va_seg)
  );

  // Executing segment supplies hardware register rights in user mode
  mbag_seg_match #(.NSEG(NSEG)) u_pc_match (
    .table_in  (table_q),
    .vaddr_in  (cpu_pc_in),
    .hit_out   (pc_hit),
    .entry_out (pc_seg)
  );

  // Translation and memory permission
  always_comb begin
    if (mode == MODE_USER && !mem_cmd_in.cop) begin
      next_paddr = {4'h0, mem_cmd_in.vaddr} + {va_seg.offset, 4'h0};
    end else begin
      next_paddr = {psw_high[7:4], mem_cmd_in.vaddr};
    end
  end

  always_comb begin
    logic [16:0] ram_off;
    ram_off = {1'b0, next_paddr[15:0]};
    region  = region_of(next_paddr);
    is_rd   = mem_cmd_in.op == OP_READ;
    is_wr   = mem_cmd_in.op == OP_WRITE;
    is_ex   = mem_cmd_in.op == OP_EXEC;
    in_acm  = in_rng(next_paddr, `MBAG_ACM_LO, `MBAG_ACM_HI);
    in_srow = in_rng(next_paddr, `MBAG_SROW_LO, `MBAG_SROW_HI);
    in_xwin = region == REG_ARAM && ram_off >= {1'b0, xw_base} &&
              ram_off < ({1'b0, xw_base} + {1'b0, xw_size});
    mem_ok  = 1'b0;
    if (mem_cmd_in.cop) begin
      mem_ok = (is_rd && (region == REG_EEE || region == REG_AEE)) ||
               (!is_ex && region == REG_CRAM);
    end else begin
      case (mode)
        MODE_BOOT: begin
          mem_ok = (!is_wr && region == REG_TROM) || region == REG_EEE ||
                   (!is_ex && region == REG_ERAM) || (is_rd && in_srow);
        end
        MODE_TEST: begin
          mem_ok = (!is_wr && (region == REG_TROM || region == REG_AROM)) ||
                   region == REG_MEE || region == REG_EEE || region == REG_AEE ||
                   (!is_ex && (region == REG_ERAM || region == REG_ARAM ||
                               region == REG_CRAM));
        end
        MODE_EMU: begin
          mem_ok = (!is_wr && region == REG_TROM) || region == REG_EEE ||
                   (!is_ex && region == REG_ERAM) || (is_rd && in_srow) ||
                   (is_rd && in_acm) || (!is_ex && in_xwin);
        end
        MODE_SYS: begin
          mem_ok = (!is_wr && region == REG_AROM) || region == REG_AEE ||
                   (!is_ex && region == REG_ARAM);
        end
        MODE_USER: begin
          mem_ok = va_hit && va_seg.rights[mem_cmd_in.op == OP_EXEC ? `MBAG_RT_X :
                   mem_cmd_in.op == OP_WRITE ? `MBAG_RT_W : `MBAG_RT_R] &&
                   ((!is_wr && region == REG_AROM) || region == REG_AEE ||
                    (!is_ex && region == REG_ARAM));
        end
        default: mem_ok = 1'b0;
      endcase
    end
  end

  // Answer one cycle after the request; memory enabled only on grant
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mem_grant_out <= 1'b0;
      mem_deny_out  <= 1'b0;
      mem_paddr_out <= '0;
      mem_op_out    <= OP_READ;
    end else begin
      mem_grant_out <= mem_req_in && mem_ok;
      mem_deny_out  <= mem_req_in && !mem_ok;
      mem_paddr_out <= (mem_req_in && mem_ok) ? next_paddr : '0;
      mem_op_out    <= mem_cmd_in.op;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fault_vaddr <= '0;
    end else if (mem_req_in && !mem_ok) begin
      fault_vaddr <= mem_cmd_in.vaddr;
    end
  end

  // Register access guard
  always_comb begin
    grp     = group_of(sfr_addr_in);
    hw_comp = sfr_addr_in[5:3];
    sfr_ok  = 1'b0;
    case (mode)
      MODE_BOOT, MODE_TEST: sfr_ok = grp != GRP_NONE;
      MODE_EMU: begin
        sfr_ok = (grp == GRP_FW && !sfr_wr_in) || grp == GRP_EOS ||
                 (grp == GRP_HW && (sfr_wr_in ? fw_ctrl_high[hw_comp] :
                                                fw_ctrl_low[hw_comp])) ||
                 (!sfr_wr_in && sfr_addr_in == `MBAG_SFR_PSW);
      end
      MODE_SYS: begin
        sfr_ok = grp == GRP_SEG || grp == GRP_SYS || grp == GRP_FW || grp == GRP_HW;
      end
      MODE_USER: begin
        sfr_ok = (grp == GRP_HW && pc_hit && pc_seg.hw[hw_comp]) ||
                 (!sfr_wr_in && sfr_addr_in == `MBAG_SFR_PSW);
      end
      default: sfr_ok = 1'b0;
    endcase
    if (grp == GRP_GEN) sfr_ok = 1'b1;
    if (grp == GRP_SEG && mode != MODE_SYS) sfr_ok = 1'b0;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sfr_grant_out <= 1'b0;
      sfr_deny_out  <= 1'b0;
      sfr_we_out    <= 1'b0;
      sfr_rdata_out <= '0;
    end else begin
      sfr_grant_out <= sfr_req_in && sfr_ok;
      sfr_deny_out  <= sfr_req_in && !sfr_ok;
      sfr_we_out    <= sfr_req_in && sfr_wr_in && sfr_ok;
      sfr_rdata_out <= (sfr_req_in && !sfr_wr_in && sfr_ok) ? sfr_rdata_in : '0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) mode_out <= MODE_BOOT;
    else mode_out <= mode;
  end

  // Configuration port; own registers obey the same mode policy
  always_comb begin
    cfg_tbl   = cfg_addr_in[9:8] == `MBAG_TBL_SEL;
    cfg_wr_ok = 1'b0;
    cfg_rd_ok = 1'b0;
    if (cfg_tbl) begin
      cfg_wr_ok = mode == MODE_SYS;
      cfg_rd_ok = mode == MODE_SYS;
    end else begin
      cfg_wr_ok = (mode == MODE_SYS || mode == MODE_BOOT || mode == MODE_TEST) &&
                  cfg_addr_in < `MBAG_REG_STAT;
      cfg_rd_ok = cfg_wr_ok || cfg_addr_in == `MBAG_REG_PSW ||
                  cfg_addr_in == `MBAG_REG_STAT ||
                  (mode == MODE_EMU && cfg_addr_in <= `MBAG_REG_XSH) ||
                  (mode != MODE_EMU && mode != MODE_USER && cfg_addr_in == `MBAG_REG_FAULT);
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      psw_high     <= `MBAG_PSW_RST;
      fw_ctrl_low  <= '0;
      fw_ctrl_high <= '0;
      xw_base      <= '0;
      xw_size      <= '0;
    end else if (cfg_wr_in && cfg_wr_ok && !cfg_tbl) begin
      case (cfg_addr_in)
        `MBAG_REG_PSW: psw_high     <= cfg_wdata_in[7:0];
        `MBAG_REG_FWL: fw_ctrl_low  <= cfg_wdata_in[7:0];
        `MBAG_REG_FWH: fw_ctrl_high <= cfg_wdata_in[7:0];
        `MBAG_REG_XBL: xw_base[7:0] <= cfg_wdata_in[7:0];
        `MBAG_REG_XBH: xw_base[15:8] <= cfg_wdata_in[7:0];
        `MBAG_REG_XSL: xw_size[7:0] <= cfg_wdata_in[7:0];
        `MBAG_REG_XSH: xw_size[15:8] <= cfg_wdata_in[7:0];
        default: ;
      endcase
    end
  end

  // Reset leaves every segment rightless, so no CPU memory access is granted in user mode
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NSEG; i++) table_q[i] <= '0;
    end else if (cfg_wr_in && cfg_wr_ok && cfg_tbl) begin
      case (cfg_addr_in[1:0])
        2'h0: begin
          table_q[cfg_addr_in[7:2]].rights <= cfg_wdata_in[2:0];
          table_q[cfg_addr_in[7:2]].hw     <= cfg_wdata_in[15:8];
        end
        2'h1: table_q[cfg_addr_in[7:2]].first  <= cfg_wdata_in;
        2'h2: table_q[cfg_addr_in[7:2]].last   <= cfg_wdata_in;
        default: table_q[cfg_addr_in[7:2]].offset <= cfg_wdata_in;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_rdata_out <= '0;
    end else if (cfg_rd_in && cfg_rd_ok) begin
      if (cfg_tbl) begin
        case (cfg_addr_in[1:0])
          2'h0: cfg_rdata_out <= {table_q[cfg_addr_in[7:2]].hw, 5'h00,
                                  table_q[cfg_addr_in[7:2]].rights};
          2'h1: cfg_rdata_out <= table_q[cfg_addr_in[7:2]].first;
          2'h2: cfg_rdata_out <= table_q[cfg_addr_in[7:2]].last;
          default: cfg_rdata_out <= table_q[cfg_addr_in[7:2]].offset;
        endcase
      end else begin
        case (cfg_addr_in)
          `MBAG_REG_PSW:   cfg_rdata_out <= {8'h00, psw_high};
          `MBAG_REG_FWL:   cfg_rdata_out <= {8'h00, fw_ctrl_low};
          `MBAG_REG_FWH:   cfg_rdata_out <= {8'h00, fw_ctrl_high};
          `MBAG_REG_XBL:   cfg_rdata_out <= {8'h00, xw_base[7:0]};
          `MBAG_REG_XBH:   cfg_rdata_out <= {8'h00, xw_base[15:8]};
          `MBAG_REG_XSL:   cfg_rdata_out <= {8'h00, xw_size[7:0]};
          `MBAG_REG_XSH:   cfg_rdata_out <= {8'h00, xw_size[15:8]};
          `MBAG_REG_STAT:  cfg_rdata_out <= {13'h0000, mode};
          `MBAG_REG_FAULT: cfg_rdata_out <= fault_vaddr;
          default:         cfg_rdata_out <= '0;
        endcase
      end
    end else begin
      cfg_rdata_out <= '0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_user_miss;
    mem_req_in && !mem_cmd_in.cop && mode == MODE_USER && !va_hit;
  endsequence
  sequence s_sys_aram_rd;
    mem_req_in && !mem_cmd_in.cop && mode == MODE_SYS && mem_cmd_in.op == OP_READ &&
    region == REG_ARAM;
  endsequence

  a_mem_one_answer: assert property (mem_req_in |=> mem_grant_out != mem_deny_out)
    else $error("memory request not answered exactly once");
  a_mem_idle_quiet: assert property (!mem_req_in |=> !mem_grant_out && !mem_deny_out
    && mem_paddr_out == '0)
    else $error("memory answer without request");
  a_user_miss_deny: assert property (s_user_miss |=> mem_deny_out && !mem_grant_out)
    else $error("user access outside segments granted");
  a_sys_ram_grant: assert property (s_sys_aram_rd |=>
    mem_grant_out && mem_paddr_out == $past(next_paddr))
    else $error("system read of application RAM refused");
  a_manuf_reserved: assert property (mem_req_in && region == REG_MEE &&
    (mode != MODE_TEST || mem_cmd_in.cop) |=> mem_deny_out)
    else $error("manufacturer area reached outside test mode");
  a_cop_no_exec: assert property (mem_req_in && mem_cmd_in.cop &&
    mem_cmd_in.op == OP_EXEC |=> mem_deny_out)
    else $error("coprocessor execute granted");
  a_seg_sfr_sys: assert property (sfr_req_in && group_of(sfr_addr_in) == GRP_SEG &&
    mode != MODE_SYS |=> sfr_deny_out && !sfr_we_out)
    else $error("segmentation register open outside system mode");
  a_gen_sfr_open: assert property (sfr_req_in && group_of(sfr_addr_in) == GRP_GEN
    |=> sfr_grant_out)
    else $error("general register access denied");
  a_deny_zero: assert property (sfr_deny_out |-> sfr_rdata_out == '0 && !sfr_we_out)
    else $error("denied register access leaked");
  a_psw_user_lock: assert property (cfg_wr_in && mode == MODE_USER |=>
    $stable(psw_high) && $stable(fw_ctrl_low))
    else $error("user mode changed guard registers");
endmodule : mbag_guard
`default_nettype wire

/* mbag_reg_model.sv */
// Register file stand-in beside the guard: answers reads with an address pattern.
// Assumes the guard samples the read data in the cycle of its request.
`timescale 1ns/1ps
`default_nettype none
module mbag_reg_model (
  input  wire logic       sfr_req_in,
  input  wire logic [7:0] sfr_addr_in,
  output logic      [7:0] sfr_rdata_out
);
  // Unselected cycles show another pattern, so a stale value never matches
  assign sfr_rdata_out = sfr_req_in ? ~sfr_addr_in : sfr_addr_in;
endmodule : mbag_reg_model
`default_nettype wire

/* test_mode_based_access_guard.sv */
// Self-checking testbench of the access guard: modes, memory and register checks.
// Assumes the package, the constants header and the register model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "mbag_consts.svh"
module test_mode_based_access_guard;
  import mbag_pkg::*;
  logic          clk_in = 1'b0;
  logic          sys_rst_in = 1'b1;
  logic [1:0]    mode_state_in = 2'h0;
  logic [9:0]    cfg_addr_in = 10'h000;
  logic [15:0]   cfg_wdata_in = 16'h0000;
  logic          cfg_wr_in = 1'b0;
  logic          cfg_rd_in = 1'b0;
  logic [15:0]   cfg_rdata_out;
  logic          mem_req_in = 1'b0;
  mbag_mem_req_s mem_cmd_in = '0;
  logic          cop_sel = 1'b0;
  logic          mem_grant_out;
  logic          mem_deny_out;
  logic [19:0]   mem_paddr_out;
  mbag_op_e      mem_op_out;
  logic [15:0]   cpu_pc_in = 16'h0000;
  logic          sfr_req_in = 1'b0;
  logic          sfr_wr_in = 1'b0;
  logic [7:0]    sfr_addr_in = 8'h00;
  logic [7:0]    sfr_rdata_in;
  logic          sfr_grant_out;
  logic          sfr_deny_out;
  logic          sfr_we_out;
  logic [7:0]    sfr_rdata_out;
  mbag_mode_e    mode_out;
  int            num_errors = 0;
  int            comparisons = 0;

  always #50 clk_in = ~clk_in;

  mbag_guard dut (.clk_in, .sys_rst_in, .mode_state_in, .cfg_addr_in, .cfg_wdata_in,
    .cfg_wr_in, .cfg_rd_in, .cfg_rdata_out, .mem_req_in, .mem_cmd_in, .mem_grant_out,
    .mem_deny_out, .mem_paddr_out, .mem_op_out, .cpu_pc_in, .sfr_req_in, .sfr_wr_in,
    .sfr_addr_in, .sfr_rdata_in, .sfr_grant_out, .sfr_deny_out, .sfr_we_out,
    .sfr_rdata_out, .mode_out);
  mbag_reg_model u_regs (.sfr_req_in, .sfr_addr_in, .sfr_rdata_out(sfr_rdata_in));

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic cfg_wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    @(posedge clk_in);
    cfg_wr_in <= 1'b0;
  endtask : cfg_wr

  task automatic cfg_rd(input logic [9:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge clk_in);
    cfg_rd_in <= 1'b0;
    @(negedge clk_in);
    check(cfg_rdata_out, exp);
  endtask : cfg_rd

  // Deny must come with a zero address, so memory is never reached
  task automatic mem(input mbag_op_e op, input logic [15:0] va, input logic g,
                     input logic [19:0] pa);
    @(posedge clk_in);
    mem_req_in <= 1'b1;
    mem_cmd_in <= '{op: op, cop: cop_sel, vaddr: va};
    @(posedge clk_in);
    mem_req_in <= 1'b0;
    @(negedge clk_in);
    check({mem_grant_out, mem_deny_out}, {g, ~g});
    check(mem_paddr_out, g ? pa : 20'h00000);
    check(mem_op_out, op);
  endtask : mem

  task automatic sfr(input logic wr, input logic [7:0] a, input logic g);
    @(posedge clk_in);
    sfr_req_in <= 1'b1;
    sfr_wr_in <= wr;
    sfr_addr_in <= a;
    @(posedge clk_in);
    sfr_req_in <= 1'b0;
    @(negedge clk_in);
    check({sfr_grant_out, sfr_deny_out, sfr_we_out}, {g, ~g, g & wr});
    // Cast keeps the inversion at 8 bits inside the 20-bit compare
    check(sfr_rdata_out, (g & ~wr) ? 8'(~a) : 8'h00);
  endtask : sfr

  task automatic set_mode(input logic [1:0] s, input mbag_mode_e exp);
    @(posedge clk_in);
    mode_state_in <= s;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    check(mode_out, exp);
  endtask : set_mode

  initial begin
    repeat (3000) @(posedge clk_in);
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    mem(OP_READ, 16'h0400, 1'b0, 20'h00000);
    set_mode(2'h0, MODE_USER);
    cfg_wr(`MBAG_REG_PSW, 16'h0041);
    cfg_rd(`MBAG_REG_PSW, 16'h0000);
    sfr(1'b0, 8'h05, 1'b1);
    sfr(1'b0, 8'h20, 1'b0);
    sfr(1'b1, 8'h20, 1'b0);
    $display("test user_after_reset done");
    set_mode(2'h1, MODE_BOOT);
    mem(OP_EXEC, 16'h0100, 1'b1, 20'h00100);
    cfg_wr(`MBAG_REG_PSW, 16'h0042);
    cfg_wr(`MBAG_REG_FWL, 16'h0001);
    // Byte registers: window base 0x0500, size 0x0100 via high bytes
    cfg_wr(`MBAG_REG_XBH, 16'h0005);
    cfg_wr(`MBAG_REG_XSH, 16'h0001);
    mem(OP_EXEC, 16'h0100, 1'b0, 20'h00000);
    set_mode(2'h2, MODE_TEST);
    mem(OP_READ, 16'h0600, 1'b1, 20'h40600);
    mem(OP_EXEC, 16'h0600, 1'b0, 20'h00000);
    set_mode(2'h0, MODE_EMU);
    mem(OP_WRITE, 16'h0100, 1'b1, 20'h40100);
    mem(OP_READ, 16'h0500, 1'b1, 20'h40500);
    mem(OP_READ, 16'h0600, 1'b0, 20'h00000);
    sfr(1'b0, 8'h80, 1'b1);
    sfr(1'b0, 8'h88, 1'b0);
    sfr(1'b1, 8'h80, 1'b0);
    cfg_rd(`MBAG_REG_STAT, 16'h0003);
    $display("test boot_test_emulation done");
    set_mode(2'h1, MODE_BOOT);
    cfg_wr(`MBAG_REG_PSW, 16'h0021);
    mem(OP_READ, 16'h0010, 1'b0, 20'h00000);
    cop_sel = 1'b1;
    mem(OP_READ, 16'h0100, 1'b1, 20'h20100);
    mem(OP_EXEC, 16'h0100, 1'b0, 20'h00000);
    cfg_wr(`MBAG_REG_PSW, 16'h0041);
    mem(OP_WRITE, 16'h2000, 1'b1, 20'h42000);
    cop_sel = 1'b0;
    set_mode(2'h0, MODE_SYS);
    mem(OP_READ, 16'h0400, 1'b1, 20'h40400);
    mem(OP_READ, 16'h0100, 1'b0, 20'h00000);
    cfg_rd(`MBAG_REG_FAULT, 16'h0100);
    sfr(1'b1, 8'h20, 1'b1);
    cfg_wr(10'h100, 16'h0101);
    cfg_wr(10'h101, 16'h1000);
    cfg_wr(10'h102, 16'h10FF);
    cfg_wr(10'h103, 16'h4000);
    cfg_wr(`MBAG_REG_PSW, 16'h0000);
    $display("test system done");
    cpu_pc_in <= 16'h1000;
    set_mode(2'h0, MODE_USER);
    mem(OP_READ, 16'h1010, 1'b1, 20'h41010);
    mem(OP_WRITE, 16'h1010, 1'b0, 20'h00000);
    mem(OP_READ, 16'h1100, 1'b0, 20'h00000);
    cfg_rd(10'h101, 16'h0000);
    $display("test user_segments done");
    finish_test();
  end
endmodule : test_mode_based_access_guard
`default_nettype wire
